// file: logic/cic_pkg.sv
// Package of constants, register map and types for the contact input conditioner
package cic_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int unsigned NUM_INPUTS = 8;
  localparam int unsigned NUM_BUILTIN = 4;
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned DEB_W = 10;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 17;
  localparam logic [9:0] DEB_MIN_MS = 10'h001;
  localparam logic [9:0] DEB_MAX_MS = 10'h3e8;
  localparam logic [9:0] DEB_RESET_MS = 10'h00a;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_TRIG_EN = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0c;
  localparam logic [7:0] OFS_SYNC_SEL = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;
  localparam logic [7:0] OFS_PRESENT = 8'h18;
  localparam logic [7:0] OFS_DEB_BASE = 8'h20;
  localparam logic [7:0] OFS_EVENT_CNT_BASE = 8'h40;

  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] POLARITY_RESET = 8'h00;
  localparam logic [7:0] TRIG_EN_RESET = 8'h00;
  localparam logic CONTROL_RESET = 1'b0;
  localparam int unsigned SYNC_INPUT_LSB = 0;
  localparam int unsigned SYNC_KIND_LSB = 4;

  typedef enum logic [1:0] {
    CIC_SYNC_NONE,
    CIC_SYNC_MINUTE,
    CIC_SYNC_SECOND
  } cic_sync_kind_e;

  typedef struct packed {
    cic_sync_kind_e kind;
    logic [2:0]     input_index;
  } cic_sync_sel_s;

  localparam cic_sync_sel_s SYNC_SEL_RESET = '{kind: CIC_SYNC_NONE, input_index: 3'h0};

  typedef struct packed {
    logic [NUM_INPUTS-1:0] rise;
    logic [NUM_INPUTS-1:0] fall;
    logic [NUM_INPUTS-1:0] level;
  } cic_edges_s;

endpackage

// file: logic/cic_tick_gen.sv
// One-millisecond tick generator for the debounce timers
`timescale 1ns/100ps
module cic_tick_gen #(
  parameter int unsigned CYCLES = cic_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  output logic      tick
);

  logic [cic_pkg::TICK_W-1:0] count;
  wire                         wrap = (count == cic_pkg::TICK_W'(CYCLES - 1));

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clk_en) begin
      count <= wrap ? '0 : count + 1'b1;
      tick  <= wrap;
    end
  end

endmodule

// file: logic/cic_debounce.sv
// Synchroniser and debounce filter for one contact input
`timescale 1ns/100ps
module cic_debounce (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic       tick,
  input  wire logic [9:0] deb_ms,
  input  wire logic       raw_in,
  output logic            stable
);

  logic       sync_a;
  logic       sync_b;
  logic [9:0] elapsed;
  wire        differs = (sync_b != stable);
  wire        expired = (elapsed >= deb_ms);

  // ----------------------------------------
  // Filter
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      elapsed <= '0;
      stable  <= 1'b0;
    end else if (clk_en) begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      if (!differs) begin
        elapsed <= '0;
      end else if (expired) begin
        stable  <= sync_b;
        elapsed <= '0;
      end else if (tick) begin
        elapsed <= elapsed + 1'b1;
      end
    end
  end

endmodule

// file: logic/cic_top.sv
// Contact input conditioner: debounce, pulse events, clock alignment and fault trigger
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/100ps
module cic_top #(
  parameter int unsigned TICK_CYCLES = cic_pkg::TICK_CYCLES
) (
  // ----------------------------------------
  // Clocking
  // ----------------------------------------
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // ----------------------------------------
  // Contacts and events
  // ----------------------------------------
  input  wire logic [7:0]  sense_in,
  input  wire logic [3:0]  expansion_present,
  input  wire logic        analog_fault_trig,
  output logic [7:0]       input_event,
  output logic             second_align_pulse,
  output logic             minute_align_pulse,
  output logic             ext_fault_event,
  output logic             fault_record_start
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0]             transition_pulse_mode;
  logic [7:0]             polarity_invert;
  logic [7:0]             trig_en;
  logic                   ext_trig_enable;
  cic_pkg::cic_sync_sel_s sync_sel;
  logic [9:0]             deb_ms [cic_pkg::NUM_PAIRS];
  logic [7:0]             stable;
  logic [7:0]             stable_q;
  logic                   trig_blocked;
  logic [3:0]             present_q1;
  logic [3:0]             present_q2;
  logic                   analog_q1;
  logic                   analog_q2;
  logic                   tick;
  logic                   wr_pend;
  logic [7:0]             wr_addr;
  cic_pkg::cic_edges_s    edges;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire        addr_phase = hsel && hready && htrans[1];
  wire [7:0]  rd_addr    = haddr[7:0];
  wire        do_write   = wr_pend;
  wire        wr_mode    = do_write && (wr_addr == cic_pkg::OFS_MODE);
  wire        wr_pol     = do_write && (wr_addr == cic_pkg::OFS_POLARITY);
  wire        wr_trig    = do_write && (wr_addr == cic_pkg::OFS_TRIG_EN);
  wire        wr_ctrl    = do_write && (wr_addr == cic_pkg::OFS_CONTROL);
  wire        wr_sync    = do_write && (wr_addr == cic_pkg::OFS_SYNC_SEL);
  wire        wr_deb_any = do_write && (wr_addr[7:5] == cic_pkg::OFS_DEB_BASE[7:5]) && (wr_addr[1:0] == 2'h0);
  wire [1:0]  wr_pair    = wr_addr[4:3];
  wire [9:0]  deb_new    = hwdata[9:0];
  wire        deb_ok     = (deb_new >= cic_pkg::DEB_MIN_MS) && (deb_new <= cic_pkg::DEB_MAX_MS);
  wire [1:0]  sync_kind  = hwdata[cic_pkg::SYNC_KIND_LSB +: 2];
  wire [2:0]  sync_idx   = hwdata[cic_pkg::SYNC_INPUT_LSB +: 3];
  // second source limited to built-in inputs
  wire        sync_ok    = (sync_kind == 2'(cic_pkg::CIC_SYNC_NONE))
                        || (sync_kind == 2'(cic_pkg::CIC_SYNC_MINUTE))
                        || ((sync_kind == 2'(cic_pkg::CIC_SYNC_SECOND)) && !sync_idx[2]);
  wire        deb_word   = (rd_addr[7:5] == cic_pkg::OFS_DEB_BASE[7:5]) && (rd_addr[1:0] == 2'h0);

  // built-in always present, expansion by strap
  wire [7:0]  present    = {present_q2, 4'hf};

  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (deb_word) begin
      // both words of a pair read the shared value
      rd_mux = {22'h00_0000, deb_ms[rd_addr[4:3]]};
    end else begin
      unique case (rd_addr)
        cic_pkg::OFS_MODE:     rd_mux = {24'h00_0000, transition_pulse_mode};
        cic_pkg::OFS_POLARITY: rd_mux = {24'h00_0000, polarity_invert};
        cic_pkg::OFS_TRIG_EN:  rd_mux = {24'h00_0000, trig_en};
        cic_pkg::OFS_CONTROL:  rd_mux = {30'h0000_0000, trig_blocked, ext_trig_enable};
        cic_pkg::OFS_SYNC_SEL: rd_mux = {26'h000_0000, sync_sel.kind, 1'b0, sync_sel.input_index};
        cic_pkg::OFS_STATE:    rd_mux = {24'h00_0000, stable};
        cic_pkg::OFS_PRESENT:  rd_mux = {24'h00_0000, present};
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Zero wait states and always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Writes land in the data phase, when hwdata stands
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (clk_en) begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= rd_addr;
    end
  end

  // Read data held until the next read address phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && addr_phase && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      transition_pulse_mode <= cic_pkg::MODE_RESET;
      polarity_invert       <= cic_pkg::POLARITY_RESET;
      trig_en               <= cic_pkg::TRIG_EN_RESET;
      ext_trig_enable       <= cic_pkg::CONTROL_RESET;
      sync_sel              <= cic_pkg::SYNC_SEL_RESET;
    end else if (clk_en) begin
      if (wr_mode) transition_pulse_mode <= hwdata[7:0];
      if (wr_pol) polarity_invert <= hwdata[7:0];
      if (wr_trig) trig_en <= hwdata[7:0];
      if (wr_ctrl) ext_trig_enable <= hwdata[0];
      if (wr_sync && sync_ok) sync_sel <= cic_pkg::cic_sync_sel_s'({sync_kind, sync_idx});
    end
  end

  // ----------------------------------------
  // Per-pair debounce settings
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < cic_pkg::NUM_PAIRS; p++) begin : g_pair
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          deb_ms[p] <= cic_pkg::DEB_RESET_MS;
        end else if (clk_en) begin
          // either input's word writes the pair
          if (wr_deb_any && wr_pair == 2'(p) && deb_ok) deb_ms[p] <= deb_new;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Tick and per-input filters
  // ----------------------------------------
  cic_tick_gen #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .tick     (tick)
  );

  genvar i;
  generate
    for (i = 0; i < cic_pkg::NUM_INPUTS; i++) begin : g_in
      cic_debounce u_deb (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .tick     (tick),
        .deb_ms   (deb_ms[i/2]),
        .raw_in   (sense_in[i]),
        .stable   (stable[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  // Absent expansion inputs float, so they are masked out
  assign edges = '{rise:  stable & ~stable_q & present,
                   fall:  ~stable & stable_q & present,
                   level: stable & present};

  wire [7:0] pol_edge = (edges.rise & ~polarity_invert) | (edges.fall & polarity_invert);
  wire [7:0] next_event = (transition_pulse_mode & (edges.rise | edges.fall))
                        | (~transition_pulse_mode & pol_edge);

  // ----------------------------------------
  // Sync sources
  // ----------------------------------------
  // sync source edge follows polarity
  wire sync_edge = pol_edge[sync_sel.input_index];
  wire next_second = sync_edge && (sync_sel.kind == cic_pkg::CIC_SYNC_SECOND) && !sync_sel.input_index[2];
  wire next_minute = sync_edge && (sync_sel.kind == cic_pkg::CIC_SYNC_MINUTE);

  // ----------------------------------------
  // Fault trigger arbitration
  // ----------------------------------------
  // closing edge of an enabled input
  wire [7:0] trig_hits = edges.rise & trig_en;
  wire       any_hit   = |trig_hits;
  // re-arm once all enabled inputs released
  wire       all_rel   = ~|(edges.level & trig_en);
  // first wins, simultaneous hits give one event
  wire       next_fault = any_hit && !trig_blocked;

  // block until release, new hit wins over re-arm
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_blocked <= 1'b0;
    end else if (clk_en) begin
      if (next_fault) trig_blocked <= 1'b1;
      else if (all_rel) trig_blocked <= 1'b0;
    end
  end

  // ----------------------------------------
  // Event outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stable_q           <= 8'h00;
      input_event        <= 8'h00;
      second_align_pulse <= 1'b0;
      minute_align_pulse <= 1'b0;
      ext_fault_event    <= 1'b0;
    end else if (clk_en) begin
      stable_q           <= stable;
      input_event        <= next_event;
      second_align_pulse <= next_second;
      minute_align_pulse <= next_minute;
      ext_fault_event    <= next_fault;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // two flops before any logic reads a pin
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      present_q1 <= 4'h0;
      present_q2 <= 4'h0;
      analog_q1  <= 1'b0;
      analog_q2  <= 1'b0;
    end else if (clk_en) begin
      present_q1 <= expansion_present;
      present_q2 <= present_q1;
      analog_q1  <= analog_fault_trig;
      analog_q2  <= analog_q1;
    end
  end

  // external event passes only when external trigger enabled, analog always
  assign fault_record_start = (ext_fault_event && ext_trig_enable) || analog_q2;

endmodule

// file: bench/cic_contact_model.sv
// Behavioural model of the external dry contacts, with bounce on every change
`timescale 1ns/100ps
module cic_contact_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] target,
  output logic      [7:0] sense_in
);
  logic [7:0] goal  = 8'h00;
  logic [7:0] prior = 8'h00;
  logic [3:0] chat  = 4'h0;

  initial sense_in = 8'h00;

  // ----------------------------------------
  // Contact bounce
  // ----------------------------------------
  // Real contacts chatter, so the filter must ride out several swings
  always @(posedge core_clk) begin
    if (target !== goal) begin
      prior <= goal;
      goal  <= target;
      chat  <= 4'h9;
    end else if (chat != 4'h0) begin
      chat     <= chat - 4'h1;
      sense_in <= chat[0] ? goal : prior;
    end
  end
endmodule

// file: bench/cic_checker.sv
// Port-level assertions for the contact input conditioner
`timescale 1ns/100ps
module cic_checker (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        analog_fault_trig,
  input wire logic [7:0]  input_event,
  input wire logic        second_align_pulse,
  input wire logic        minute_align_pulse,
  input wire logic        ext_fault_event,
  input wire logic        fault_record_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_event_single;
    (input_event & $past(input_event)) == 8'h00;
  endproperty
  a_event_single: assert property (p_event_single) else $error("input event longer than one cycle");
  property p_ext_once;
    ext_fault_event |=> !ext_fault_event [*8];
  endproperty
  a_ext_once: assert property (p_ext_once) else $error("repeated fault trigger");
  property p_rec_cause;
    fault_record_start && !ext_fault_event |-> $past(analog_fault_trig, 2);
  endproperty
  a_rec_cause: assert property (p_rec_cause) else $error("record start without cause");
  property p_analog_pass;
    $past(analog_fault_trig, 2) |-> fault_record_start;
  endproperty
  a_analog_pass: assert property (p_analog_pass) else $error("analog trigger gated");
  property p_sec_pulse;
    second_align_pulse |=> !second_align_pulse;
  endproperty
  a_sec_pulse: assert property (p_sec_pulse) else $error("second pulse too long");
  property p_min_pulse;
    minute_align_pulse |=> !minute_align_pulse;
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("minute pulse too long");
  property p_rdata_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready and okay");

  c_ext: cover property (ext_fault_event);
  c_sec: cover property (second_align_pulse);
  c_rec: cover property (fault_record_start && !ext_fault_event);
endmodule

bind cic_top cic_checker u_chk (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .analog_fault_trig(analog_fault_trig), .input_event(input_event), .second_align_pulse(second_align_pulse),
  .minute_align_pulse(minute_align_pulse), .ext_fault_event(ext_fault_event),
  .fault_record_start(fault_record_start));

// file: bench/testbench.sv
// Self-checking bench for the contact input conditioner
`timescale 1ns/100ps
module testbench;
  logic        core_clk = 1'b0;
  logic        reset_n  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0000_0000;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0000_0000;
  logic        analog   = 1'b0;
  logic [3:0]  present  = 4'hf;
  logic [7:0]  target   = 8'h00;
  logic [31:0] rd, ext_cnt = '0, rec_cnt = '0, sec_cnt = '0, min_cnt = '0;
  logic [3:0]  ev_cnt [8] = '{default: 4'h0};
  wire  logic [31:0] hrdata;
  wire  logic [7:0]  input_event, sense_in;
  wire  logic        hreadyout, hresp, sec_p, min_p, ext_ev, rec_start;
  int          n_fail = 0, check_count = 0, cycles = 0;

  cic_contact_model u_contacts (.core_clk(core_clk), .target(target), .sense_in(sense_in));
  // A short tick keeps each debounce wait to a few hundred cycles
  localparam int unsigned BENCH_TICK = 100;

  cic_top #(.TICK_CYCLES(BENCH_TICK))
    DUT (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sense_in(sense_in), .expansion_present(present),
    .analog_fault_trig(analog), .input_event(input_event), .second_align_pulse(sec_p),
    .minute_align_pulse(min_p), .ext_fault_event(ext_ev), .fault_record_start(rec_start));

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Event counting and timeout
  // ----------------------------------------
  always @(posedge core_clk) begin
    for (int i = 0; i < 8; i++) ev_cnt[i] <= ev_cnt[i] + 4'(input_event[i] === 1'b1);
    ext_cnt <= ext_cnt + 32'(ext_ev === 1'b1);
    rec_cnt <= rec_cnt + 32'(rec_start === 1'b1);
    sec_cnt <= sec_cnt + 32'(sec_p === 1'b1);
    min_cnt <= min_cnt + 32'(min_p === 1'b1);
  end

  // Five settle waits of 300 cycles dominate the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5_000) begin
      n_fail++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Waits past the longest acceptance of a 1 ms debounce, then compares the per-input counts
  task automatic settle(input logic [7:0] t, input logic [31:0] exp);
    logic [31:0] got;
    target <= t;
    repeat (300) @(posedge core_clk);
    for (int i = 0; i < 8; i++) got[4*i+:4] = ev_cnt[i];
    check(got, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(cic_pkg::OFS_MODE, {24'h00_0000, cic_pkg::MODE_RESET});
    rdchk(cic_pkg::OFS_POLARITY, {24'h00_0000, cic_pkg::POLARITY_RESET});
    rdchk(cic_pkg::OFS_TRIG_EN, {24'h00_0000, cic_pkg::TRIG_EN_RESET});
    rdchk(cic_pkg::OFS_CONTROL, 32'h0000_0000);
    rdchk(cic_pkg::OFS_PRESENT, 32'h0000_00ff);
    rdchk(cic_pkg::OFS_SYNC_SEL, 32'h0000_0000);
    rdchk(cic_pkg::OFS_DEB_BASE + 8'h1c, {22'h00_0000, cic_pkg::DEB_RESET_MS});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, cic_pkg::OFS_DEB_BASE + 8'(8 * i + 4), 32'h0000_0001);
      rdchk(cic_pkg::OFS_DEB_BASE + 8'(8 * i), 32'h0000_0001);
    end
    bus(1'b1, cic_pkg::OFS_DEB_BASE, 32'h0000_03e9);
    bus(1'b1, cic_pkg::OFS_DEB_BASE + 8'h04, 32'h0000_0000);
    rdchk(cic_pkg::OFS_DEB_BASE, 32'h0000_0001);
    bus(1'b1, cic_pkg::OFS_SYNC_SEL, 32'h0000_0024);
    rdchk(cic_pkg::OFS_SYNC_SEL, 32'h0000_0000);
    bus(1'b1, cic_pkg::OFS_SYNC_SEL, 32'h0000_0020);
    rdchk(cic_pkg::OFS_SYNC_SEL, 32'h0000_0020);
    bus(1'b1, 8'h80, 32'hffff_ffff);
    rdchk(8'h80, 32'h0000_0000);
  endtask

  // Input 1 both edges, input 2 inverted, inputs 4 and 5 arm the fault trigger
  task automatic t_events();
    bus(1'b1, cic_pkg::OFS_MODE, 32'h0000_0002);
    bus(1'b1, cic_pkg::OFS_POLARITY, 32'h0000_0004);
    bus(1'b1, cic_pkg::OFS_TRIG_EN, 32'h0000_0030);
    bus(1'b1, cic_pkg::OFS_CONTROL, 32'h0000_0001);
    settle(8'h3f, 32'h0011_1011);
    check(ext_cnt, 32'h0000_0001);
    check(rec_cnt, 32'h0000_0001);
    check(sec_cnt, 32'h0000_0001);
    rdchk(cic_pkg::OFS_STATE, 32'h0000_003f);
    rdchk(cic_pkg::OFS_CONTROL, 32'h0000_0003);
    analog <= 1'b1;
    @(posedge core_clk);
    analog <= 1'b0;
    repeat (5) @(posedge core_clk);
    check(rec_cnt, 32'h0000_0002);
    settle(8'h2f, 32'h0011_1011);
    settle(8'h3f, 32'h0012_1011);
    check(ext_cnt, 32'h0000_0001);
    settle(8'h00, 32'h0012_1121);
    bus(1'b1, cic_pkg::OFS_SYNC_SEL, 32'h0000_0013);
    bus(1'b1, cic_pkg::OFS_CONTROL, 32'h0000_0000);
    settle(8'h18, 32'h0013_2121);
    check(ext_cnt, 32'h0000_0002);
    check(rec_cnt, 32'h0000_0002);
    check(min_cnt, 32'h0000_0001);
    rdchk(cic_pkg::OFS_STATE, 32'h0000_0018);
    check(sec_cnt, 32'h0000_0001);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_events();
    end_sim();
  end
endmodule
